// ---- arvc_reg_bank.sv ----
// Configuration register bank for output rate, filter, mode, clock, chop and reference control
`timescale 1ns/100ps
`default_nettype none

module arvc_reg_bank
  import arvc_pkg::*;
(
  input wire logic ref_clk_i, // 125 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic wr_en_i, // Write strobe, one cycle
  input wire logic rd_en_i, // Read strobe, one cycle
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic power_down_i, // Device is in power-down
  output logic [7:0] rdata_o, // Read data, registered
  output logic rvalid_o, // Read data valid, one cycle
  output logic cfg_change_o, // Pulse after any mapped write
  output logic chop_en_o, // Global chop active
  output logic ext_clk_sel_o, // External conversion clock selected
  output logic single_shot_o, // Single-shot conversion mode
  output logic low_latency_o, // Low-latency filter selected
  output logic [3:0] output_rate_field_o, // Raw rate code
  output logic [11:0] rate_tenth_sps_o, // Rate in tenths of SPS, zero if undecoded
  output logic vref_low_monitor_o, // Low-level monitor enabled
  output logic vref_high_monitor_o, // High-level monitor enabled
  output logic vref_pull_together_o, // Pull-together resistor enabled
  output logic positive_buffer_bypass_o, // Positive buffer bypassed
  output logic negative_buffer_bypass_o, // Negative buffer bypassed
  output logic [1:0] vsource_select_o, // Reference route code
  output logic vsource_sel_rsvd_o, // Reserved route code written
  output logic internal_vsource_on_o, // Internal reference powered now
  output logic vsource_pwr_rsvd_o, // Reserved power code written
  output logic pga_rail_monitor_enable_o, // Rail monitor enabled
  output logic low_side_switch_o, // Low-side switch closed
  output logic [3:0] excitation_magnitude_o, // Excitation current code
  output logic exc_without_vsource_o, // Currents asked while reference off
  output logic buffers_in_path_o // Internal reference used with a buffer active
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Rate codes beyond the decoded set report zero so the user sees no guessed figure
  function automatic logic [11:0] rate_decode(input logic [3:0] code);
    case (code)
      4'h0: rate_decode = 12'h019;
      4'h1: rate_decode = 12'h032;
      4'h2: rate_decode = 12'h064;
      4'h3: rate_decode = 12'h0a6;
      4'h4: rate_decode = 12'h0c8;
      4'h5: rate_decode = 12'h1f4;
      4'h6: rate_decode = 12'h258;
      4'h7: rate_decode = 12'h3e8;
      default: rate_decode = 12'h000;
    endcase
  endfunction

  // Mapped-address test for the change pulse; it lists the same addresses as the write decode
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ARVC_SAMPLE_SPEED_ADDR) || (a == ARVC_VSOURCE_CTRL_ADDR) ||
               (a == ARVC_EXC_CUR_ONE_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Stored bytes, the last read answer and the registered rate figure
  logic [7:0] speed_q, speed_d;
  logic [7:0] vsrc_q, vsrc_d;
  logic [7:0] exc_q, exc_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic change_q, change_d;
  logic [11:0] rate_q, rate_d;

  // Next-state for writes and reads; unmapped writes are dropped, unmapped reads give zero
  always_comb begin
    speed_d = speed_q;
    vsrc_d = vsrc_q;
    exc_d = exc_q;
    change_d = 1'b0;
    rdata_d = rdata_q;
    rvalid_d = rd_en_i;
    if (wr_en_i) begin
      case (addr_i)
        ARVC_SAMPLE_SPEED_ADDR: speed_d = wdata_i;
        ARVC_VSOURCE_CTRL_ADDR: vsrc_d = wdata_i;
        ARVC_EXC_CUR_ONE_ADDR: exc_d = wdata_i & ARVC_EXC_WR_MASK;
        default: exc_d = exc_q;
      endcase
      change_d = addr_hit(addr_i);
    end
    // Read returns the stored value, so a same-cycle write shows next read
    if (rd_en_i) begin
      case (addr_i)
        ARVC_SAMPLE_SPEED_ADDR: rdata_d = speed_q;
        ARVC_VSOURCE_CTRL_ADDR: rdata_d = vsrc_q;
        ARVC_EXC_CUR_ONE_ADDR: rdata_d = exc_q & ARVC_EXC_WR_MASK;
        default: rdata_d = 8'h00;
      endcase
    end
    rate_d = rate_decode(speed_d[ARVC_RATE_LSB +: 4]);
  end

  // Register stage with documented reset values
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      speed_q <= ARVC_SAMPLE_SPEED_RST;
      vsrc_q <= ARVC_VSOURCE_CTRL_RST;
      exc_q <= ARVC_EXC_CUR_ONE_RST;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      change_q <= 1'b0;
      rate_q <= rate_decode(ARVC_SAMPLE_SPEED_RST[ARVC_RATE_LSB +: 4]);
    end else begin
      speed_q <= speed_d;
      vsrc_q <= vsrc_d;
      exc_q <= exc_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      change_q <= change_d;
      rate_q <= rate_d;
    end
  end

  // ----------------------------------------------------------------
  // Field decodes toward the converter
  // ----------------------------------------------------------------
  // Enum-typed copies keep the decodes below readable
  arvc_mon_t mon_code;
  arvc_vsel_t vsel_code;
  arvc_vpwr_t vpwr_code;

  // Enum views of the stored fields
  always_comb begin
    mon_code = arvc_mon_t'(vsrc_q[ARVC_MON_LSB +: 2]);
    vsel_code = arvc_vsel_t'(vsrc_q[ARVC_VSEL_LSB +: 2]);
    vpwr_code = arvc_vpwr_t'(vsrc_q[ARVC_VPWR_LSB +: 2]);
  end

  // Sample-speed fields
  assign chop_en_o = speed_q[ARVC_CHOP_BIT];
  assign ext_clk_sel_o = speed_q[ARVC_CLK_SRC_BIT];
  assign single_shot_o = speed_q[ARVC_MODE_BIT];
  assign low_latency_o = speed_q[ARVC_FILTER_BIT];
  assign output_rate_field_o = speed_q[ARVC_RATE_LSB +: 4];
  assign rate_tenth_sps_o = rate_q;

  // Monitor decode; every enabled code keeps the low monitor on
  always_comb begin
    vref_low_monitor_o = 1'b0;
    vref_high_monitor_o = 1'b0;
    vref_pull_together_o = 1'b0;
    case (mon_code)
      ARVC_MON_OFF: vref_low_monitor_o = 1'b0;
      ARVC_MON_LOW: vref_low_monitor_o = 1'b1;
      ARVC_MON_LOW_HIGH: begin
        vref_low_monitor_o = 1'b1;
        vref_high_monitor_o = 1'b1;
      end
      ARVC_MON_LOW_PULL: begin
        vref_low_monitor_o = 1'b1;
        vref_pull_together_o = 1'b1;
      end
      default: vref_low_monitor_o = 1'b0;
    endcase
  end

  // Buffers and route
  assign positive_buffer_bypass_o = vsrc_q[ARVC_PBUF_BIT];
  assign negative_buffer_bypass_o = vsrc_q[ARVC_NBUF_BIT];
  assign vsource_select_o = vsel_code;
  assign vsource_sel_rsvd_o = (vsel_code == ARVC_VSEL_RSVD);

  // Internal reference power; reserved code keeps it off as the safe choice
  always_comb begin
    case (vpwr_code)
      ARVC_VPWR_OFF: internal_vsource_on_o = 1'b0;
      ARVC_VPWR_ON_PD_OFF: internal_vsource_on_o = !power_down_i;
      ARVC_VPWR_ALWAYS: internal_vsource_on_o = 1'b1;
      default: internal_vsource_on_o = 1'b0;
    endcase
  end
  assign vsource_pwr_rsvd_o = (vpwr_code == ARVC_VPWR_RSVD);

  // Excitation fields; the low-side switch opens by itself in power-down
  assign pga_rail_monitor_enable_o = exc_q[ARVC_RAIL_BIT];
  assign low_side_switch_o = exc_q[ARVC_LSW_BIT] && !power_down_i;
  assign excitation_magnitude_o = exc_q[ARVC_MAG_LSB +: 4];

  // Advisory flags only; the controller owns these usages, the bank does not block them
  assign exc_without_vsource_o = (exc_q[ARVC_MAG_LSB +: 4] != 4'h0) &&
                                 !internal_vsource_on_o;
  assign buffers_in_path_o = (vsel_code == ARVC_VSEL_INT) &&
                             !(vsrc_q[ARVC_PBUF_BIT] && vsrc_q[ARVC_NBUF_BIT]);

  // Bus answers
  // Read data holds until the next read, so a slow consumer can still take it
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign cfg_change_o = change_q;

endmodule

`default_nettype wire

// ---- arvc_pkg.sv ----
// Package with register map, field positions and reset values for the rate and reference bank
package arvc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ARVC_SAMPLE_SPEED_ADDR = 8'h04;
  localparam logic [7:0] ARVC_VSOURCE_CTRL_ADDR = 8'h05;
  localparam logic [7:0] ARVC_EXC_CUR_ONE_ADDR = 8'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ARVC_SAMPLE_SPEED_RST = 8'h14;
  localparam logic [7:0] ARVC_VSOURCE_CTRL_RST = 8'h10;
  localparam logic [7:0] ARVC_EXC_CUR_ONE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Sample-speed field positions
  // ----------------------------------------------------------------
  localparam int ARVC_CHOP_BIT = 7;
  localparam int ARVC_CLK_SRC_BIT = 6;
  localparam int ARVC_MODE_BIT = 5;
  localparam int ARVC_FILTER_BIT = 4;
  localparam int ARVC_RATE_LSB = 0;

  // ----------------------------------------------------------------
  // Voltage-source control field positions
  // ----------------------------------------------------------------
  localparam int ARVC_MON_LSB = 6;
  localparam int ARVC_PBUF_BIT = 5;
  localparam int ARVC_NBUF_BIT = 4;
  localparam int ARVC_VSEL_LSB = 2;
  localparam int ARVC_VPWR_LSB = 0;

  // ----------------------------------------------------------------
  // Excitation-current field positions and writable mask
  // ----------------------------------------------------------------
  localparam int ARVC_RAIL_BIT = 7;
  localparam int ARVC_LSW_BIT = 6;
  localparam int ARVC_MAG_LSB = 0;
  localparam logic [7:0] ARVC_EXC_WR_MASK = 8'hcf;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ARVC_MON_OFF = 2'b00,
    ARVC_MON_LOW = 2'b01,
    ARVC_MON_LOW_HIGH = 2'b10,
    ARVC_MON_LOW_PULL = 2'b11
  } arvc_mon_t;

  typedef enum logic [1:0] {
    ARVC_VSEL_EXT0 = 2'b00,
    ARVC_VSEL_EXT1 = 2'b01,
    ARVC_VSEL_INT = 2'b10,
    ARVC_VSEL_RSVD = 2'b11
  } arvc_vsel_t;

  typedef enum logic [1:0] {
    ARVC_VPWR_OFF = 2'b00,
    ARVC_VPWR_ON_PD_OFF = 2'b01,
    ARVC_VPWR_ALWAYS = 2'b10,
    ARVC_VPWR_RSVD = 2'b11
  } arvc_vpwr_t;

endpackage

// ---- arvc_reg_bank_properties.sv ----
// Concurrent checks on the ports of the rate and reference register bank
`timescale 1ns/100ps
`default_nettype none

module arvc_props (
  input wire logic ref_clk_i, // Bank clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  input wire logic power_down_i, // Power-down state
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic [7:0] rdata_o, // Read data
  input wire logic rvalid_o, // Read data valid
  input wire logic cfg_change_o, // Change pulse
  input wire logic chop_en_o, // Chop field
  input wire logic ext_clk_sel_o, // Clock source field
  input wire logic single_shot_o, // Mode field
  input wire logic low_latency_o, // Filter field
  input wire logic positive_buffer_bypass_o, // Positive buffer bypass
  input wire logic negative_buffer_bypass_o, // Negative buffer bypass
  input wire logic vref_low_monitor_o, // Low monitor
  input wire logic vref_high_monitor_o, // High monitor
  input wire logic vref_pull_together_o, // Pull-together
  input wire logic internal_vsource_on_o, // Internal source powered
  input wire logic low_side_switch_o, // Low-side switch
  input wire logic [3:0] output_rate_field_o, // Rate code
  input wire logic [1:0] vsource_select_o, // Route code
  input wire logic [11:0] rate_tenth_sps_o // Decoded rate
);
  logic [7:0] wd_q;
  logic map_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Data and address class of the last edge, so consequents avoid nested $past
  always_ff @(posedge ref_clk_i) begin
    wd_q <= wdata_i;
    map_q <= addr_i inside {8'h04, 8'h05, 8'h06};
  end

  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  a_read_valid: assert property (rd_en_i |=> rvalid_o)
    else $error("read strobe gave no valid");
  a_cfg_pulse: assert property (wr_en_i |=> cfg_change_o == map_q)
    else $error("change pulse does not match write address");
  a_exc_zero_bits: assert property (rd_en_i && addr_i == 8'h06 |=> rdata_o[5:4] == 2'h0)
    else $error("excitation read shows set reserved bits");
  a_speed_write: assert property (wr_en_i && addr_i == 8'h04 |=>
    {chop_en_o, ext_clk_sel_o, single_shot_o, low_latency_o, output_rate_field_o} == wd_q)
    else $error("sample speed fields differ from written byte");
  a_vsrc_write: assert property (wr_en_i && addr_i == 8'h05 |=>
    {positive_buffer_bypass_o, negative_buffer_bypass_o, vsource_select_o} == wd_q[5:2])
    else $error("buffer or route fields differ from written byte");
  a_mon_decode: assert property (wr_en_i && addr_i == 8'h05 |=>
    {vref_low_monitor_o, vref_high_monitor_o, vref_pull_together_o} ==
    {wd_q[7:6] != 2'h0, wd_q[7:6] == 2'h2, wd_q[7:6] == 2'h3})
    else $error("monitor decode wrong");
  a_vsrc_power: assert property (wr_en_i && addr_i == 8'h05 |=> internal_vsource_on_o ==
    (wd_q[1:0] == 2'h2 || (wd_q[1:0] == 2'h1 && !power_down_i)))
    else $error("internal source power decode wrong");
  a_switch_pd: assert property (power_down_i |-> !low_side_switch_o)
    else $error("low side switch closed in power down");
  a_rate_decode: assert property (
    output_rate_field_o == 4'h3 |-> rate_tenth_sps_o == 12'h0a6)
    else $error("rate code three not decoded");

  // Main scenarios reached
  c_exc_read: cover property (rd_en_i && addr_i == 8'h06);
  c_vsrc_write: cover property (wr_en_i && addr_i == 8'h05);
  c_pd_on: cover property (power_down_i && internal_vsource_on_o);
endmodule

bind arvc_reg_bank arvc_props u_props (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i),
  .power_down_i(power_down_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .rvalid_o(rvalid_o),
  .cfg_change_o(cfg_change_o),
  .chop_en_o(chop_en_o),
  .ext_clk_sel_o(ext_clk_sel_o),
  .single_shot_o(single_shot_o),
  .low_latency_o(low_latency_o),
  .positive_buffer_bypass_o(positive_buffer_bypass_o),
  .negative_buffer_bypass_o(negative_buffer_bypass_o),
  .vref_low_monitor_o(vref_low_monitor_o),
  .vref_high_monitor_o(vref_high_monitor_o),
  .vref_pull_together_o(vref_pull_together_o),
  .internal_vsource_on_o(internal_vsource_on_o),
  .low_side_switch_o(low_side_switch_o),
  .output_rate_field_o(output_rate_field_o),
  .vsource_select_o(vsource_select_o),
  .rate_tenth_sps_o(rate_tenth_sps_o)
);
`default_nettype wire

// ---- arvc_reg_bank_tb_top.sv ----
// Self-checking testbench for the rate and reference register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin \
  $display("[ERR] %s expected %h seen %h", n, e, s); bad_count++; end end

module arvc_reg_bank_tb_top import arvc_pkg::*; ;
  localparam logic [11:0] RATE_TAB [8] = '{12'h019, 12'h032, 12'h064, 12'h0a6,
    12'h0c8, 12'h1f4, 12'h258, 12'h3e8};
  logic ref_clk_i;
  logic rst_n_i = 0, wr_en_i = 0, rd_en_i = 0, power_down_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic rvalid_o, cfg_change_o, chop_en_o, ext_clk_sel_o, single_shot_o, low_latency_o;
  logic vref_low_monitor_o, vref_high_monitor_o, vref_pull_together_o;
  logic positive_buffer_bypass_o, negative_buffer_bypass_o, vsource_sel_rsvd_o;
  logic internal_vsource_on_o, vsource_pwr_rsvd_o, pga_rail_monitor_enable_o;
  logic low_side_switch_o, exc_without_vsource_o, buffers_in_path_o;
  logic [3:0] output_rate_field_o, excitation_magnitude_o;
  logic [1:0] vsource_select_o;
  logic [11:0] rate_tenth_sps_o;
  logic [7:0] mdl [3];
  logic [31:0] rnd = 32'h0000001f;
  int bad_count = 0, checks_done = 0, cyc = 0;
  wire [7:0] spd_w = {chop_en_o, ext_clk_sel_o, single_shot_o, low_latency_o, output_rate_field_o};
  wire [8:0] vs_w = {vref_low_monitor_o, vref_high_monitor_o, vref_pull_together_o,
    positive_buffer_bypass_o, negative_buffer_bypass_o, vsource_select_o,
    vsource_sel_rsvd_o, vsource_pwr_rsvd_o};
  wire [5:0] ex_w = {pga_rail_monitor_enable_o, low_side_switch_o, excitation_magnitude_o};
  wire [1:0] adv_w = {exc_without_vsource_o, buffers_in_path_o};

  arvc_reg_bank uut (.*);

  // 125 MHz clock
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [11:0] rate_exp(input logic [3:0] c);
    return c[3] ? 12'h000 : RATE_TAB[c[2:0]];
  endfunction

  // One strobe cycle; the read expectation uses the model before the write lands
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    logic m;
    m = a inside {8'h04, 8'h05, 8'h06};
    @(negedge ref_clk_i);
    wr_en_i = w;
    rd_en_i = r;
    addr_i = a;
    wdata_i = d;
    @(negedge ref_clk_i);
    wr_en_i = 0;
    rd_en_i = 0;
    `CHK("rvalid", r, rvalid_o)
    if (r) `CHK("rdata", m ? mdl[a[1:0]] : 8'h00, rdata_o)
    `CHK("cfg_change", w && m, cfg_change_o)
    if (w && m) mdl[a[1:0]] = d & ((a == 8'h06) ? 8'hcf : 8'hff);
  endtask

  // Every decoded output against the model and the power-down level
  task automatic check_fields();
    logic [7:0] s, v, e;
    logic on;
    // Let a fresh power-down level ripple through the decodes before looking
    #1;
    s = mdl[0];
    v = mdl[1];
    e = mdl[2];
    on = (v[1:0] == 2'h2) || (v[1:0] == 2'h1 && !power_down_i);
    `CHK("speed", s, spd_w)
    `CHK("rate", rate_exp(s[3:0]), rate_tenth_sps_o)
    `CHK("monitor", {v[7:6] != 2'h0, v[7:6] == 2'h2, v[7:6] == 2'h3}, vs_w[8:6])
    `CHK("route", {v[5:2], v[3:2] == 2'h3, v[1:0] == 2'h3}, vs_w[5:0])
    `CHK("vsrc_on", on, internal_vsource_on_o)
    `CHK("excite", {e[7], e[6] & !power_down_i, e[3:0]}, ex_w)
    `CHK("advice", {e[3:0] != 4'h0 && !on, v[3:2] == 2'h2 && !(v[5] && v[4])}, adv_w)
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far beyond the fewer than two hundred cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mdl = '{8'h14, 8'h10, 8'h00};
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1;
    check_fields();
    for (int a = 4; a < 8; a++) op(0, 1, a[7:0], 8'h00);
    op(1, 0, 8'h06, 8'hff);
    op(0, 1, 8'h06, 8'h00);
    op(1, 1, 8'h05, 8'hac);
    op(1, 0, 8'h07, 8'h5a);
    op(0, 1, 8'h07, 8'h00);
    // Every rate, monitor, route and power code, with random neighbours
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      op(1, 0, 8'h04, {rnd[7:4], i[3:0]});
      op(1, 0, 8'h05, {i[1:0], rnd[9:8], i[3:2], i[1:0]});
      op(1, 0, 8'h06, rnd[23:16]);
      power_down_i = rnd[24];
      check_fields();
      op(0, 1, 8'h04 + {6'h00, rnd[26:25]}, 8'h00);
    end
    // Reset again in mid-run
    @(negedge ref_clk_i);
    rst_n_i = 0;
    @(negedge ref_clk_i);
    rst_n_i = 1;
    mdl = '{8'h14, 8'h10, 8'h00};
    check_fields();
    `CHK("rdata_rst", 8'h00, rdata_o)
    `CHK("rvalid_rst", 1'b0, rvalid_o)
    final_report();
  end
endmodule

`default_nettype wire
